/* ers_status_regs.v */
`timescale 1ns/1ns
`include "ers_map.vh"
// Notes on behaviour
// - Range flags come from fixed-threshold comparators, never from converted samples.
// - Upper flags: bits 23 RIGHT_LEG_DRIVE, 22 LA, 21 LL, 20 RA, 19 V1, 18 V2, 13 CE.
// - Upper flag is 1 when electrode is above 2.4 V, else 0.
// - Lower flags: bits 12 RIGHT_LEG_DRIVE, 11 LA, 10 LL, 9 RA, 8 V1, 7 V2, 2 CE.
// - Lower flag is 1 when electrode is below 0.2 V, else 0.
// - Both registers return only on an addressed register read, never in frames.
// - Operating status bit 3 sets when the digital core reports a failure.
// - Bit 2 reads busy after reset until configuration loaded, then ready.
// - Bit 1 sets when PLL loses lock after being enabled and locked.
// - Bit 1 clears on operating status read or power enable bit cleared.
// - Bit 0 follows PLL lock state through one core_clk register stage.
module ers_status_regs (
  input wire core_clk,
  input wire nrst,
  // Comparator outputs, order RIGHT_LEG_DRIVE, LA, LL, RA, V1, V2, CE
  input wire [6:0] cmpOverHi,
  input wire [6:0] cmpUnderLo,
  // Digital core and PLL state
  input wire coreFault,
  input wire cfgLoaded,
  input wire pllLocked,
  input wire powerEnableBit,
  // Register access from the serial command decoder
  input wire rdStb,
  input wire wrStb,
  input wire [7:0] regAddr,
  output reg [23:0] rdData_r,
  output reg rdValid_r,
  output reg rdHit_r
);
  wire [23:0] rangeWord;
  reg [23:0] opWord;
  reg intErr_r;
  reg cfgBusy_r;
  reg armed_r;
  reg lockLost_r;
  reg lockSeen_r;
  reg lockLost_nxt;
  reg armed_nxt;
  wire opRead;
  wire rangeRead;

  // Direct comparator flags, no sample path involved
  ers_range_pack uPack (
    .overHi(cmpOverHi),
    .underLo(cmpUnderLo),
    .rangeWord(rangeWord)
  );

  assign opRead = rdStb & (regAddr == `ERS_ADDR_OPSTAT);
  assign rangeRead = rdStb & (regAddr == `ERS_ADDR_RANGE);

  // Sticky error and configuration-busy flags
  always @(posedge core_clk) begin
    if (!nrst) begin
      intErr_r <= 1'b0;
      cfgBusy_r <= 1'b1;
      lockSeen_r <= 1'b0;
    end else begin
      if (coreFault) begin
        intErr_r <= 1'b1;
      end
      if (cfgLoaded) begin
        cfgBusy_r <= 1'b0;
      end
      lockSeen_r <= pllLocked;
    end
  end

  // Lock-lost tracking; arm once locked while powered
  always @* begin
    armed_nxt = armed_r;
    lockLost_nxt = lockLost_r;
    if (!powerEnableBit) begin
      armed_nxt = 1'b0;
      lockLost_nxt = 1'b0;
    end else begin
      if (opRead) begin
        lockLost_nxt = 1'b0;
      end
      if (pllLocked) begin
        armed_nxt = 1'b1;
      end else if (armed_r) begin
        lockLost_nxt = 1'b1;
        armed_nxt = 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      lockLost_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
      lockLost_r <= lockLost_nxt;
    end
  end

  // Operating status word, reserved bits zero
  always @* begin
    opWord = 24'h00_0000;
    opWord[`ERS_OP_INTERR] = intErr_r;
    opWord[`ERS_OP_CFGBUSY] = cfgBusy_r;
    opWord[`ERS_OP_LOCKLOST] = lockLost_r;
    opWord[`ERS_OP_LOCKED] = lockSeen_r;
  end

  // Read answer one cycle after the strobe; writes have no effect
  always @(posedge core_clk) begin
    if (!nrst) begin
      rdData_r <= 24'h00_0000;
      rdValid_r <= 1'b0;
      rdHit_r <= 1'b0;
    end else begin
      rdValid_r <= rdStb;
      rdHit_r <= opRead | rangeRead;
      if (opRead) begin
        rdData_r <= opWord;
      end else if (rangeRead) begin
        rdData_r <= rangeWord;
      end else begin
        rdData_r <= 24'h00_0000;
      end
    end
  end
endmodule // ers_status_regs

/* ers_map.vh */
`ifndef ERS_MAP_VH
`define ERS_MAP_VH
// Register addresses (8-bit address field of the read command)
`define ERS_ADDR_RANGE 8'h1e
`define ERS_ADDR_OPSTAT 8'h1f
// Range status field positions
`define ERS_UP_RLD 23
`define ERS_UP_LA 22
`define ERS_UP_LL 21
`define ERS_UP_RA 20
`define ERS_UP_V1 19
`define ERS_UP_V2 18
`define ERS_UP_CE 13
`define ERS_LO_RLD 12
`define ERS_LO_LA 11
`define ERS_LO_LL 10
`define ERS_LO_RA 9
`define ERS_LO_V1 8
`define ERS_LO_V2 7
`define ERS_LO_CE 2
// Operating status field positions
`define ERS_OP_INTERR 3
`define ERS_OP_CFGBUSY 2
`define ERS_OP_LOCKLOST 1
`define ERS_OP_LOCKED 0
// Reset values
`define ERS_RANGE_RST 24'h00_0000
`define ERS_OPSTAT_RST 24'h00_0004
`endif

/* ers_range_pack.v */
`timescale 1ns/1ns
`include "ers_map.vh"
// Places the seven upper and seven lower comparator results into the range word
module ers_range_pack (
  input wire [6:0] overHi,
  input wire [6:0] underLo,
  output reg [23:0] rangeWord
);
  // Electrode order: RIGHT_LEG_DRIVE, LA, LL, RA, V1, V2, CE; other bits stay zero
  always @* begin
    rangeWord = `ERS_RANGE_RST;
    rangeWord[`ERS_UP_RLD] = overHi[6];
    rangeWord[`ERS_UP_LA] = overHi[5];
    rangeWord[`ERS_UP_LL] = overHi[4];
    rangeWord[`ERS_UP_RA] = overHi[3];
    rangeWord[`ERS_UP_V1] = overHi[2];
    rangeWord[`ERS_UP_V2] = overHi[1];
    rangeWord[`ERS_UP_CE] = overHi[0];
    rangeWord[`ERS_LO_RLD] = underLo[6];
    rangeWord[`ERS_LO_LA] = underLo[5];
    rangeWord[`ERS_LO_LL] = underLo[4];
    rangeWord[`ERS_LO_RA] = underLo[3];
    rangeWord[`ERS_LO_V1] = underLo[2];
    rangeWord[`ERS_LO_V2] = underLo[1];
    rangeWord[`ERS_LO_CE] = underLo[0];
  end
endmodule // ers_range_pack

/* ers_host.sv */
`timescale 1ns/1ns
// Host side: one register read at a time
module ers_host(input wire core_clk, input wire [23:0] rdData_r, input wire rdValid_r,
  output reg rdStb, output reg [7:0] regAddr);
  initial begin
    rdStb = 0;
    regAddr = 8'h00;
  end
  // Command held for one edge; an operating status read clears lock-lost
  task rd(input [7:0] a, output [23:0] d, output v);
    begin
      rdStb = 1;
      regAddr = a;
      @(posedge core_clk);
      #5;
      d = rdData_r;
      v = rdValid_r;
      rdStb = 0;
      regAddr = ~a;
    end
  endtask
endmodule // ers_host

/* ers_status_regs_asserts.sv */
`timescale 1ns/1ns
module ers_sr_chk(input wire core_clk, nrst, rdStb, wrStb, coreFault, cfgLoaded, pllLocked, powerEnableBit,
  input wire [6:0] cmpOverHi, cmpUnderLo, input wire [7:0] regAddr, input wire [23:0] rdData_r,
  input wire rdValid_r, rdHit_r);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Operating status read
  wire op = rdStb && regAddr == 8'h1f;
  property p_v; rdStb |=> rdValid_r; endproperty
  a_v: assert property (p_v) else $error("no answer");
  property p_i; !rdStb |=> !rdValid_r && rdData_r == 0; endproperty
  a_i: assert property (p_i) else $error("unasked data");
  property p_r; rdStb && regAddr == 8'h1e |=> rdHit_r && rdData_r == $past({cmpOverHi[6:1], 4'h0,
    cmpOverHi[0], cmpUnderLo[6:1], 4'h0, cmpUnderLo[0], 2'h0}); endproperty
  a_r: assert property (p_r) else $error("bad range word");
  property p_m; rdStb && regAddr != 8'h1e && !op |=> !rdHit_r && rdData_r == 0; endproperty
  a_m: assert property (p_m) else $error("unmapped hit");
  property p_z; op |=> rdHit_r && rdData_r[23:4] == 0; endproperty
  a_z: assert property (p_z) else $error("reserved set");
  property p_k; op |=> rdData_r[0] == $past(pllLocked, 2); endproperty
  a_k: assert property (p_k) else $error("lock bit");
  property p_e; op && $past(coreFault && nrst) |=> rdData_r[3]; endproperty
  a_e: assert property (p_e) else $error("error bit");
  property p_c; op && $past(cfgLoaded && nrst) |=> !rdData_r[2]; endproperty
  a_c: assert property (p_c) else $error("busy bit");
  property p_p; op && $past(!powerEnableBit && nrst) && !$past(powerEnableBit, 2) |=> !rdData_r[1]; endproperty
  a_p: assert property (p_p) else $error("lock-lost kept");
endmodule // ers_sr_chk
bind ers_status_regs ers_sr_chk u_chk (.*);

/* electrode_range_and_operating_status_tb.sv */
`timescale 1ns/1ns
module electrode_range_and_operating_status_tb;
  reg core_clk = 0, nrst = 0, wrStb = 0, coreFault = 0, cfgLoaded = 0, pllLocked = 0, powerEnableBit = 0;
  reg [6:0] cmpOverHi = 0, cmpUnderLo = 0;
  wire rdStb, rdValid_r, rdHit_r;
  wire [7:0] regAddr;
  wire [23:0] rdData_r;
  integer err_count = 0, n_checks = 0, cyc = 0, i;
  ers_status_regs dut(.*);
  ers_host h(.*);
  always #50 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  task close_out;
    begin
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task w(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #5;
    end
  endtask
  // Read and compare one word
  task rc(input [7:0] a, input [23:0] e);
    reg [23:0] d;
    reg v;
    begin
      h.rd(a, d, v);
      n_checks = n_checks + 1;
      if (d !== e || v !== 1'b1) begin
        err_count = err_count + 1;
        $display("[FAIL] reg %h exp %h got %h", a, e, d);
      end
      w(1);
    end
  endtask
  task t_reset;
    begin
      // A write pulse must leave both registers untouched
      wrStb = 1;
      w(1);
      wrStb = 0;
      rc(8'h1f, 24'h00_0004);
      rc(8'h1e, 24'h00_0000);
      rc(8'h1d, 24'h00_0000);
    end
  endtask
  // Each comparator lands on its own flag pair
  task t_range;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        cmpOverHi = 7'h01 << i;
        cmpUnderLo = 7'h01 << i;
        w(1);
        rc(8'h1e, (24'h00_0001 << (i ? 17 + i : 13)) | (24'h00_0001 << (i ? 6 + i : 2)));
      end
    end
  endtask
  // Sticky error, ready, lock loss and both clears
  task t_op;
    begin
      cfgLoaded = 1;
      coreFault = 1;
      powerEnableBit = 1;
      pllLocked = 1;
      w(1);
      cfgLoaded = 0;
      coreFault = 0;
      w(2);
      rc(8'h1f, 24'h00_0009);
      pllLocked = 0;
      w(2);
      rc(8'h1f, 24'h00_000a);
      rc(8'h1f, 24'h00_0008);
      pllLocked = 1;
      w(2);
      pllLocked = 0;
      w(2);
      powerEnableBit = 0;
      w(2);
      rc(8'h1f, 24'h00_0008);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #5 nrst = 1;
    w(1);
    t_reset;
    t_range;
    t_op;
    close_out;
  end
endmodule // electrode_range_and_operating_status_tb
